/* core/i2crs_slave.sv */
// Two-wire serial slave giving a bus master access to the internal register file.
// Assumes scl and sda arrive asynchronously and the bus is externally pulled up.
`timescale 1ns/1ns
`default_nettype none
module i2crs_slave (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic busy,
  output i2crs_pkg::i2crs_wr_t reg_wr_r
);

  // Three-stage samplers; the output changes only when stages two and three agree
  logic [2:0] scl_s_r, scl_s_nxt;
  logic [2:0] sda_s_r, sda_s_nxt;
  logic scl_f_r, scl_f_nxt;
  logic sda_f_r, sda_f_nxt;

  // Filters preset to the idle-high level so leaving reset never fakes an edge
  always_comb begin
    scl_s_nxt = {scl_s_r[1:0], scl_i};
    sda_s_nxt = {sda_s_r[1:0], sda_i};
    scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
    sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
    end
  end

  // Bus events; at 10 MHz a 400 kHz bus gives about 25 samples per bit
  // START and STOP need sda to move while the filtered clock stays high
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_f_nxt & ~scl_f_r;
  assign scl_fall = ~scl_f_nxt & scl_f_r;
  assign start_ev = scl_f_r & scl_f_nxt & sda_f_r & ~sda_f_nxt;
  assign stop_ev = scl_f_r & scl_f_nxt & ~sda_f_r & sda_f_nxt;

  // Protocol state; the pointer moves when a read byte is loaded, so a byte
  // that the master NACKs still advances it, and a STOP drops a partial byte
  i2crs_pkg::i2crs_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic first_r, first_nxt;
  logic oe_n_r, oe_n_nxt;
  // Busy is registered from the next state so it lines up with st_r
  logic busy_r, busy_nxt;
  i2crs_pkg::i2crs_wr_t wr_nxt;
  logic [7:0] rdata;

  i2crs_regmem u_mem (
    .clk(clk),
    .nrst(nrst),
    .wr(reg_wr_r),
    .raddr(ptr_r),
    .rdata_r(rdata)
  );

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    first_nxt = first_r;
    oe_n_nxt = oe_n_r;
    wr_nxt = '0;
    if (start_ev) begin
      st_nxt = i2crs_pkg::I2CRS_ST_ADDR;
      cnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
    end else if (stop_ev) begin
      st_nxt = i2crs_pkg::I2CRS_ST_IDLE;
      oe_n_nxt = 1'b1;
    end else begin
      case (st_r)
        i2crs_pkg::I2CRS_ST_ADDR, i2crs_pkg::I2CRS_ST_RX: begin
          if (scl_rise && cnt_r != i2crs_pkg::I2CRS_BYTE_BITS) begin
            sh_nxt = {sh_r[6:0], sda_f_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == i2crs_pkg::I2CRS_BYTE_BITS) begin
            if (st_r == i2crs_pkg::I2CRS_ST_ADDR) begin
              if (sh_r[7:1] == i2crs_pkg::I2CRS_DEV_ADDR) begin
                oe_n_nxt = 1'b0;
                st_nxt = i2crs_pkg::I2CRS_ST_AACK;
                first_nxt = 1'b1;
              end else begin
                st_nxt = i2crs_pkg::I2CRS_ST_SKIP;
              end
            end else begin
              oe_n_nxt = 1'b0;
              st_nxt = i2crs_pkg::I2CRS_ST_RACK;
              if (first_r) begin
                ptr_nxt = sh_r;
                first_nxt = 1'b0;
              end else begin
                wr_nxt.valid = 1'b1;
                wr_nxt.addr = ptr_r;
                wr_nxt.data = sh_r;
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
        end
        i2crs_pkg::I2CRS_ST_AACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (sh_r[0] == i2crs_pkg::I2CRS_DIR_READ) begin
              sh_nxt = rdata;
              ptr_nxt = ptr_r + 8'h01;
              oe_n_nxt = rdata[7];
              st_nxt = i2crs_pkg::I2CRS_ST_TX;
            end else begin
              oe_n_nxt = 1'b1;
              st_nxt = i2crs_pkg::I2CRS_ST_RX;
            end
          end
        end
        i2crs_pkg::I2CRS_ST_RACK: begin
          if (scl_fall) begin
            oe_n_nxt = 1'b1;
            cnt_nxt = 4'h0;
            st_nxt = i2crs_pkg::I2CRS_ST_RX;
          end
        end
        i2crs_pkg::I2CRS_ST_TX: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == i2crs_pkg::I2CRS_BYTE_BITS) begin
              oe_n_nxt = 1'b1;
              st_nxt = i2crs_pkg::I2CRS_ST_MACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_n_nxt = sh_r[6];
            end
          end
        end
        i2crs_pkg::I2CRS_ST_MACK: begin
          if (scl_rise && sda_f_r) begin
            st_nxt = i2crs_pkg::I2CRS_ST_SKIP;
          end else if (scl_fall) begin
            cnt_nxt = 4'h0;
            sh_nxt = rdata;
            ptr_nxt = ptr_r + 8'h01;
            oe_n_nxt = rdata[7];
            st_nxt = i2crs_pkg::I2CRS_ST_TX;
          end
        end
        // Unaddressed or NACKed: stay here until a START or a STOP
        i2crs_pkg::I2CRS_ST_SKIP: begin
          oe_n_nxt = 1'b1;
        end
        i2crs_pkg::I2CRS_ST_IDLE: begin
          oe_n_nxt = 1'b1;
        end
        default: begin
          st_nxt = i2crs_pkg::I2CRS_ST_IDLE;
          oe_n_nxt = 1'b1;
        end
      endcase
    end
    busy_nxt = (st_nxt != i2crs_pkg::I2CRS_ST_IDLE) && (st_nxt != i2crs_pkg::I2CRS_ST_SKIP);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= i2crs_pkg::I2CRS_ST_IDLE;
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= i2crs_pkg::I2CRS_DATA_RST;
      ptr_r <= i2crs_pkg::I2CRS_PTR_RST;
      first_r <= 1'b0;
      oe_n_r <= 1'b1;
      reg_wr_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      first_r <= first_nxt;
      oe_n_r <= oe_n_nxt;
      reg_wr_r <= wr_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Open drain: the pad only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_r;
  assign busy = busy_r;

endmodule
`default_nettype wire

/* core/i2crs_pkg.sv */
// Package for the two-wire register access slave: constants and carrier types.
// Assumes a single system clock; no other file defines these names.
package i2crs_pkg;

  // Seven-bit bus address; the read byte is {addr,1} and the write byte {addr,0}
  localparam logic [6:0] I2CRS_DEV_ADDR = 7'h25;
  localparam logic I2CRS_DIR_WRITE = 1'b0;
  localparam logic I2CRS_DIR_READ = 1'b1;

  // Bits in one byte, counted on rising clock edges
  localparam logic [3:0] I2CRS_BYTE_BITS = 4'h8;

  // Register file geometry and reset values
  localparam int I2CRS_ADDR_W = 8;
  localparam int I2CRS_DATA_W = 8;
  localparam logic [7:0] I2CRS_PTR_RST = 8'h00;
  localparam logic [7:0] I2CRS_DATA_RST = 8'h00;

  // Link timing: fastest bus clock, system clock, and the cycles in one bus period
  localparam int I2CRS_SCL_MAX_KHZ = 400;
  localparam int I2CRS_CLK_KHZ = 10000;
  localparam int I2CRS_SCL_MIN_CYC = I2CRS_CLK_KHZ / I2CRS_SCL_MAX_KHZ;

  typedef enum logic [7:0] {
    I2CRS_ST_IDLE = 8'h01,
    I2CRS_ST_ADDR = 8'h02,
    I2CRS_ST_AACK = 8'h04,
    I2CRS_ST_RX = 8'h08,
    I2CRS_ST_RACK = 8'h10,
    I2CRS_ST_TX = 8'h20,
    I2CRS_ST_MACK = 8'h40,
    I2CRS_ST_SKIP = 8'h80
  } i2crs_state_t;

  // One register write as it leaves the serial side
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } i2crs_wr_t;

endpackage

/* core/i2crs_regmem.sv */
// Register file storage for the two-wire slave: one write port, one read port.
// Assumes the caller holds addresses steady; read data appear one clock later.
`timescale 1ns/1ns
`default_nettype none
module i2crs_regmem (
  input wire logic clk,
  input wire logic nrst,
  input wire i2crs_pkg::i2crs_wr_t wr,
  input wire logic [7:0] raddr,
  output logic [7:0] rdata_r
);

  logic [7:0] mem [0:(1 << i2crs_pkg::I2CRS_ADDR_W) - 1];
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (wr.valid) begin
      mem[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= i2crs_pkg::I2CRS_DATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

/* test/i2crs_assertions.sv */
// Checker for the two-wire slave, bound to its ports.
// Assumes a pulled-up data wire and async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module i2crs_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic busy,
  input wire i2crs_pkg::i2crs_wr_t reg_wr_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_pad_low: assert property (sda_o == 1'b0)
    else $error("pad value high");
  a_wr_pulse: assert property (reg_wr_r.valid |=> !reg_wr_r.valid)
    else $error("write pulse too long");
  a_wr_busy: assert property (reg_wr_r.valid |-> busy)
    else $error("write while idle");
  a_wr_low: assert property (reg_wr_r.valid |-> !scl_i)
    else $error("write during clock high");
  a_wr_ack: assert property ($rose(reg_wr_r.valid) |-> ##[0:12] !sda_oe_n)
    else $error("written byte not acked");
  a_idle_quiet: assert property (!busy ##1 !busy |-> sda_oe_n)
    else $error("drive while not addressed");
  a_high_hold: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n))
    else $error("data moved in clock high");
  a_start_busy: assert property (scl_i && $fell(sda_i) |-> ##[2:8] busy)
    else $error("start not taken");
endmodule
bind i2crs_slave i2crs_chk i2crs_chk_inst (.clk(clk), .nrst(nrst), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .busy(busy), .reg_wr_r(reg_wr_r));
`default_nettype wire

/* test/i2crs_bm.sv */
// Bus master model: makes the clock and pulls the data wire low.
// Assumes the bench resolves the pulled-up data wire.
`timescale 1ns/1ns
`default_nettype none
module i2crs_bm (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Half bus period in ns; the default is the fastest legal clock
  int hp = i2crs_pkg::I2CRS_SCL_MIN_CYC * 50;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Pins move by non-blocking assignment so the slave's samplers never race them
  task automatic bit_io(input logic b, output logic r);
    #100 sda_low <= !b;
    #(hp - 100) scl <= 1'b1;
    #hp r = sda;
    scl <= 1'b0;
  endtask
  // Serves from idle and as a repeated start
  task automatic start;
    #100 sda_low <= 1'b0;
    #hp scl <= 1'b1;
    #hp sda_low <= 1'b1;
    #hp scl <= 1'b0;
  endtask
  task automatic stop;
    #100 sda_low <= 1'b1;
    #hp scl <= 1'b1;
    #hp sda_low <= 1'b0;
    #hp;
  endtask
  // Eight bits MSB first, then ai in the ninth slot
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
    output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ai, ao);
  endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the two-wire slave.
// Assumes the master model in i2crs_bm and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] rx;
  logic a;
  wire logic scl, m_low, sda_o, sda_oe_n, busy;
  wire i2crs_pkg::i2crs_wr_t wr;
  i2crs_pkg::i2crs_wr_t wq[$];
  wire logic sda = !m_low && (sda_oe_n || sda_o);
  logic [7:0] rp[4] = '{8'h00, 8'h7f, 8'h10, 8'hff};
  logic [7:0] rd[4] = '{8'h5a, 8'hc3, 8'h01, 8'h96};
  always #50 clk = !clk;
  i2crs_slave i2crs_slave_inst (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .busy(busy), .reg_wr_r(wr));
  i2crs_bm i2crs_bm_inst (.scl(scl), .sda_low(m_low), .sda(sda));
  always @(posedge clk) if (wr.valid === 1'b1) wq.push_back(wr);
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic ea);
    i2crs_bm_inst.xfer(b, 1'b1, rx, a);
    chk("ack", a, ea);
  endtask
  task automatic get(input logic ma, input logic [7:0] e);
    i2crs_bm_inst.xfer(8'hff, ma, rx, a);
    chk("rdata", rx, e);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #6_000_000;
    error_cnt++;
    results;
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      i2crs_bm_inst.hp = (i == 2) ? 2500 : 1250;
      i2crs_bm_inst.start;
      put(8'h4a, 1'b0);
      chk("busy", busy, 1'b1);
      put(rp[i], 1'b0);
      put(rd[i], 1'b0);
      put(~rd[i], 1'b0);
      i2crs_bm_inst.stop;
      chk("wr0", {wq[0].addr, wq[0].data}, {rp[i], rd[i]});
      chk("wr1", {wq[1].addr, wq[1].data}, {rp[i] + 8'h01, ~rd[i]});
      wq.delete();
      // Odd rows end the pointer write with a stop, even rows go straight on
      i2crs_bm_inst.start;
      put(8'h4a, 1'b0);
      put(rp[i], 1'b0);
      if (i % 2) i2crs_bm_inst.stop;
      i2crs_bm_inst.start;
      put(8'h4b, 1'b0);
      get(1'b0, rd[i]);
      get(1'b1, ~rd[i]);
      get(1'b1, 8'hff);
      chk("nack", busy, 1'b0);
      chk("rel", sda_oe_n, 1'b1);
      i2crs_bm_inst.stop;
      chk("nowr", wq.size(), 16'h0000);
    end
    // Foreign address leaves the pointer at 0x01
    i2crs_bm_inst.start;
    put(8'h4c, 1'b1);
    put(8'h00, 1'b1);
    chk("skip", busy, 1'b0);
    i2crs_bm_inst.start;
    put(8'h4b, 1'b0);
    get(1'b1, ~rd[0]);
    i2crs_bm_inst.stop;
    // Reset clears the pointer but keeps the registers
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk("rst", sda_oe_n, 1'b1);
    i2crs_bm_inst.start;
    put(8'h4b, 1'b0);
    get(1'b1, ~rd[3]);
    i2crs_bm_inst.stop;
    chk("nowr", wq.size(), 16'h0000);
    results;
  end
endmodule
`default_nettype wire
